// [verilog/dsce_engine.sv]
// command layer of the single-wire debug port
// assumes the line input is synchronous and the cpu saves its registers on entry
// Function
// - cpu-resource commands only in active debug mode
// - active mode maps debug window at top page
// - 0x62 steps x by two, reads there
// - 0x63-0x67 return pc, d, x, y, sp
// - 0x42 steps x by two, stores there
// - 0x43-0x47 load pc, d, x, y, sp
// - 0x08 resumes, acknowledge on leaving
// - 0x0c resumes, acknowledge on re-entry
// - 0x10 runs one instruction, acknowledge on return
// - 0x18 behaves exactly like resume
// - acknowledge when read ready or store done
// - opcode byte then optional sixteen-bit words
// - reads always return sixteen bits
// - window accesses hit debug store, firmware unwritable
// - no acknowledge starts while stopped; stop cancels pending
// - misaligned word access drops address lsb
// - bit starts at host fall, sixteen clocks
// - msb first; 512 idle clocks abandon transfer
// - acknowledge: 16 low, speedup, 32 clocks after
`timescale 1ns/1ps
`default_nettype none
module dsce_engine
   import dsce_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic DEBUG_LINE_I,
   input wire logic DBG_ENTER_I,
   input wire logic ACK_EN_I,
   input wire logic SYS_STOP_I,
   input wire dsce_regs_t CPU_REGS_I,
   input wire logic MEM_DONE_I,
   input wire logic [15:0] MEM_RDATA_I,
   output logic DEBUG_LINE_O,
   output logic DEBUG_LINE_OE_N_O,
   output logic DBG_ACTIVE_O,
   output logic DEBUG_WINDOW_O,
   output logic RESUME_O,
   output logic STEP_O,
   output dsce_regs_t CPU_REGS_O,
   output dsce_mem_req_t MEM_REQ_O
);

   typedef enum logic [2:0] {S_IDLE, S_RX_WORD, S_MEM, S_ACK_WAIT, S_ACK_LOW, S_ACK_HI, S_TX} dsce_state_t;

   dsce_state_t state_reg, state_next;
   logic line_q_reg;
   logic [9:0] cnt_reg;
   logic bit_live_reg;
   logic [4:0] bitcnt_reg;
   logic [15:0] shift_reg;
   logic [15:0] tx_reg;
   logic [7:0] opcode_reg;
   logic to_tx_reg;
   logic pend_reg;
   logic dm_ph_reg;
   logic [4:0] ack_cnt_reg;
   logic [4:0] low_run_reg;

   logic fall, rx_phase, sample_ev, bit_end, op_done, word_done, timeout;
   logic [7:0] opcode_now;
   logic [15:0] word_now, x_now;
   logic is_read, is_write, go_op, until_op, step_op, known_op, ack_ok;
   logic use_dbg, mem_done, dmem_we, dmem_re;
   logic [6:0] dmem_idx;
   logic [15:0] dmem_rdata;
   dsce_state_t after_ack;

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);

   function automatic logic [15:0] fetch_reg(input logic [7:0] op, input dsce_regs_t r);
      logic [15:0] v;
      v = REG_RST;
      case (op)
         OP_FETCH_PROGRAM_COUNTER: v = r.pc;
         OP_READ_D: v = r.d;
         OP_READ_X: v = r.x;
         OP_READ_Y: v = r.y;
         OP_FETCH_STACK_POINTER: v = r.sp;
         default: v = REG_RST;
      endcase
      return v;
   endfunction

   // our own drive must not look like a host edge
   assign fall = line_q_reg && !DEBUG_LINE_I && DEBUG_LINE_OE_N_O;
   assign rx_phase = (state_reg == S_IDLE) || (state_reg == S_RX_WORD);
   assign sample_ev = bit_live_reg && rx_phase && (cnt_reg == SAMPLE_TICK);
   assign bit_end = bit_live_reg && (state_reg == S_TX) && (cnt_reg == BIT_TICKS - 10'h001);
   assign op_done = sample_ev && (state_reg == S_IDLE) && (bitcnt_reg == OP_LAST_BIT);
   assign word_done = sample_ev && (state_reg == S_RX_WORD) && (bitcnt_reg == WORD_LAST_BIT);
   assign opcode_now = {shift_reg[6:0], DEBUG_LINE_I};
   assign word_now = {shift_reg[14:0], DEBUG_LINE_I};
   assign timeout = (cnt_reg == TIMEOUT_TICKS) && (bitcnt_reg != 5'h00)
      && (rx_phase || (state_reg == S_TX));
   assign x_now = CPU_REGS_O.x;

   assign is_read = (opcode_now >= OP_READ_NEXT) && (opcode_now <= OP_FETCH_STACK_POINTER);
   assign is_write = (opcode_now >= OP_WRITE_NEXT) && (opcode_now <= OP_LOAD_STACK_POINTER);
   assign go_op = op_done && DBG_ACTIVE_O
      && ((opcode_now == OP_GO) || (opcode_now == OP_LEGACY_TAG_RESUME));
   assign until_op = op_done && DBG_ACTIVE_O && (opcode_now == OP_GO_UNTIL);
   assign step_op = op_done && DBG_ACTIVE_O && (opcode_now == OP_SINGLE_STEP);
   assign known_op = is_read || is_write || (opcode_now == OP_GO) || (opcode_now == OP_LEGACY_TAG_RESUME)
      || (opcode_now == OP_GO_UNTIL) || (opcode_now == OP_SINGLE_STEP);
   assign ack_ok = ACK_EN_I && !SYS_STOP_I;
   assign after_ack = to_tx_reg ? S_TX : S_IDLE;

   // window decode; word accesses are forced even
   assign use_dbg = DBG_ACTIVE_O && (x_now[15:8] == DBG_WIN_PAGE);
   assign dmem_idx = x_now[7:1];
   assign dmem_we = (state_reg == S_MEM) && use_dbg && !dm_ph_reg && (opcode_reg == OP_WRITE_NEXT)
      && (dmem_idx < DBG_REG_WORDS);
   assign dmem_re = (state_reg == S_MEM) && use_dbg && !dm_ph_reg && (opcode_reg == OP_READ_NEXT);
   assign mem_done = (state_reg == S_MEM) && (use_dbg ? dm_ph_reg : (MEM_REQ_O.req && MEM_DONE_I));

   dsce_dbg_mem #(
      .AW(7),
      .DW(16)
   ) u_dbg_mem (
      .CLK_SYS_I(CLK_SYS_I),
      .we_i(dmem_we),
      .re_i(dmem_re),
      .addr_i(dmem_idx),
      .wdata_i(shift_reg),
      .rdata_o(dmem_rdata)
   );

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE: begin
            if (timeout) begin
               state_next = S_IDLE;
            end else if (DBG_ENTER_I && pend_reg && ack_ok) begin
               state_next = S_ACK_WAIT;
            end else if (op_done && DBG_ACTIVE_O) begin
               if (is_read) begin
                  if (opcode_now == OP_READ_NEXT) begin
                     state_next = S_MEM;
                  end else begin
                     state_next = ack_ok ? S_ACK_WAIT : S_TX;
                  end
               end else if (is_write) begin
                  state_next = S_RX_WORD;
               end else if ((go_op) && ack_ok) begin
                  state_next = S_ACK_WAIT;
               end
            end
         end
         S_RX_WORD: begin
            if (timeout) begin
               state_next = S_IDLE;
            end else if (word_done) begin
               if (opcode_reg == OP_WRITE_NEXT) begin
                  state_next = S_MEM;
               end else begin
                  state_next = ack_ok ? S_ACK_WAIT : S_IDLE;
               end
            end
         end
         S_MEM: begin
            if (mem_done) begin
               state_next = ack_ok ? S_ACK_WAIT : after_ack;
            end
         end
         S_ACK_WAIT: begin
            if (SYS_STOP_I) begin
               state_next = after_ack;
            end else if (cnt_reg >= ACK_START_TICK) begin
               state_next = S_ACK_LOW;
            end
         end
         S_ACK_LOW: begin
            if (ack_cnt_reg == ACK_LOW_TICKS - 5'h01) begin
               state_next = S_ACK_HI;
            end
         end
         S_ACK_HI: begin
            state_next = after_ack;
         end
         S_TX: begin
            if (timeout || (bit_end && (bitcnt_reg == WORD_LAST_BIT))) begin
               state_next = S_IDLE;
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_reg <= S_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // bit timer measured from the perceived host edge
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         line_q_reg <= 1'b1;
         cnt_reg <= TIMEOUT_TICKS;
         bit_live_reg <= 1'b0;
      end else begin
         line_q_reg <= DEBUG_LINE_I;
         if (fall) begin
            cnt_reg <= 10'h000;
         end else if (cnt_reg != TIMEOUT_TICKS) begin
            cnt_reg <= cnt_reg + 10'h001;
         end
         if (fall && (rx_phase || (state_reg == S_TX))) begin
            bit_live_reg <= 1'b1;
         end else if (sample_ev || bit_end || timeout) begin
            bit_live_reg <= 1'b0;
         end
      end
   end

   // shifters; msb travels first both ways
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         bitcnt_reg <= 5'h00;
         shift_reg <= REG_RST;
         tx_reg <= REG_RST;
         opcode_reg <= 8'h00;
         to_tx_reg <= 1'b0;
      end else begin
         // a finished read must not leave its count for the next opcode
         if (timeout || op_done || word_done || (bit_end && (bitcnt_reg == WORD_LAST_BIT))) begin
            bitcnt_reg <= 5'h00;
         end else if (sample_ev || bit_end) begin
            bitcnt_reg <= bitcnt_reg + 5'h01;
         end
         if (sample_ev) begin
            shift_reg <= word_now;
         end
         if (op_done && DBG_ACTIVE_O) begin
            opcode_reg <= opcode_now;
            to_tx_reg <= is_read;
            tx_reg <= fetch_reg(opcode_now, CPU_REGS_O);
         end else if (mem_done && (opcode_reg == OP_READ_NEXT)) begin
            tx_reg <= use_dbg ? dmem_rdata : MEM_RDATA_I;
         end else if (bit_end) begin
            tx_reg <= {tx_reg[14:0], 1'b0};
         end
      end
   end

   // saved cpu registers, owned here while the cpu sits in debug mode
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         CPU_REGS_O <= {5{REG_RST}};
      end else if (DBG_ENTER_I) begin
         CPU_REGS_O <= CPU_REGS_I;
      end else if (op_done && DBG_ACTIVE_O && (opcode_now == OP_READ_NEXT)) begin
         CPU_REGS_O.x <= x_now + 16'h0002;
      end else if (word_done) begin
         case (opcode_reg)
            OP_WRITE_NEXT: CPU_REGS_O.x <= x_now + 16'h0002;
            OP_LOAD_PROGRAM_COUNTER: CPU_REGS_O.pc <= word_now;
            OP_WRITE_D: CPU_REGS_O.d <= word_now;
            OP_WRITE_X: CPU_REGS_O.x <= word_now;
            OP_WRITE_Y: CPU_REGS_O.y <= word_now;
            OP_LOAD_STACK_POINTER: CPU_REGS_O.sp <= word_now;
            default: CPU_REGS_O <= CPU_REGS_O;
         endcase
      end
   end

   // user memory port; request held until the bus answers
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         MEM_REQ_O <= '0;
         dm_ph_reg <= 1'b0;
      end else begin
         dm_ph_reg <= (state_reg == S_MEM) && use_dbg && !dm_ph_reg;
         if (MEM_REQ_O.req && MEM_DONE_I) begin
            MEM_REQ_O.req <= 1'b0;
         end else if ((state_reg == S_MEM) && !use_dbg && !MEM_REQ_O.req) begin
            MEM_REQ_O.req <= 1'b1;
            MEM_REQ_O.we <= (opcode_reg == OP_WRITE_NEXT);
            MEM_REQ_O.addr <= {x_now[15:1], 1'b0};
            MEM_REQ_O.wdata <= shift_reg;
         end
      end
   end

   // run control; a pending set beats a stop clear in the same cycle
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         DBG_ACTIVE_O <= ACTIVE_RST;
         DEBUG_WINDOW_O <= ACTIVE_RST;
         RESUME_O <= 1'b0;
         STEP_O <= 1'b0;
         pend_reg <= 1'b0;
      end else begin
         RESUME_O <= go_op || until_op;
         STEP_O <= step_op;
         if (DBG_ENTER_I) begin
            DBG_ACTIVE_O <= 1'b1;
            DEBUG_WINDOW_O <= 1'b1;
         end else if (go_op || until_op || step_op) begin
            DBG_ACTIVE_O <= 1'b0;
            DEBUG_WINDOW_O <= 1'b0;
         end
         if (until_op || step_op) begin
            pend_reg <= 1'b1;
         end else if (SYS_STOP_I || DBG_ENTER_I) begin
            pend_reg <= 1'b0;
         end
      end
   end

   // line driver; only low pulses and one-clock speedups are driven
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         DEBUG_LINE_O <= 1'b1;
         DEBUG_LINE_OE_N_O <= 1'b1;
         ack_cnt_reg <= 5'h00;
      end else begin
         ack_cnt_reg <= (state_reg == S_ACK_LOW) ? ack_cnt_reg + 5'h01 : 5'h00;
         DEBUG_LINE_O <= 1'b1;
         DEBUG_LINE_OE_N_O <= 1'b1;
         case (state_reg)
            S_ACK_LOW: begin
               DEBUG_LINE_O <= 1'b0;
               DEBUG_LINE_OE_N_O <= 1'b0;
            end
            S_ACK_HI: begin
               DEBUG_LINE_OE_N_O <= 1'b0;
            end
            S_TX: begin
               if (bit_live_reg && !tx_reg[15] && (cnt_reg < TX0_SPEEDUP_TICK)) begin
                  DEBUG_LINE_O <= 1'b0;
                  DEBUG_LINE_OE_N_O <= 1'b0;
               end else if (bit_live_reg && (cnt_reg == (tx_reg[15] ? TX1_SPEEDUP_TICK : TX0_SPEEDUP_TICK))) begin
                  DEBUG_LINE_OE_N_O <= 1'b0;
               end
            end
            default: begin
               DEBUG_LINE_OE_N_O <= 1'b1;
            end
         endcase
      end
   end

   // length of the running low drive, for the pulse-shape check
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         low_run_reg <= 5'h00;
      end else if (!DEBUG_LINE_OE_N_O && !DEBUG_LINE_O) begin
         low_run_reg <= (low_run_reg == 5'h1f) ? low_run_reg : low_run_reg + 5'h01;
      end else begin
         low_run_reg <= 5'h00;
      end
   end

   property p_inactive;
      (op_done && !DBG_ACTIVE_O) |=> (state_reg == S_IDLE) && !RESUME_O && !STEP_O;
   endproperty
   a_inactive: assert property (p_inactive) else $error("command run outside debug mode");
   property p_window;
      DBG_ENTER_I |=> DEBUG_WINDOW_O && DBG_ACTIVE_O;
   endproperty
   a_window: assert property (p_window) else $error("window not mapped on entry");
   property p_read_next;
      (op_done && DBG_ACTIVE_O && (opcode_now == OP_READ_NEXT) && !DBG_ENTER_I)
         |=> (x_now == $past(x_now) + 16'h0002) && (state_reg == S_MEM);
   endproperty
   a_read_next: assert property (p_read_next) else $error("read next did not step x");
   property p_load_pc;
      (word_done && (opcode_reg == OP_LOAD_PROGRAM_COUNTER) && !DBG_ENTER_I) |=> CPU_REGS_O.pc == $past(word_now);
   endproperty
   a_load_pc: assert property (p_load_pc) else $error("pc not loaded");
   property p_go;
      go_op |=> RESUME_O && !DBG_ACTIVE_O && !pend_reg;
   endproperty
   a_go: assert property (p_go) else $error("resume not issued");
   property p_step;
      step_op |=> STEP_O && !RESUME_O && !DBG_ACTIVE_O && pend_reg;
   endproperty
   a_step: assert property (p_step) else $error("single step not issued");
   property p_mem_ack;
      (mem_done && ack_ok) |=> state_reg == S_ACK_WAIT;
   endproperty
   a_mem_ack: assert property (p_mem_ack) else $error("no acknowledge after access");
   property p_fw_protect;
      dmem_we |-> (dmem_idx < DBG_REG_WORDS) && use_dbg;
   endproperty
   a_fw_protect: assert property (p_fw_protect) else $error("firmware area written");
   property p_win_port;
      ((state_reg == S_MEM) && use_dbg) |=> !MEM_REQ_O.req;
   endproperty
   a_win_port: assert property (p_win_port) else $error("window access reached user memory");
   property p_stop;
      SYS_STOP_I |-> (state_next != S_ACK_LOW);
   endproperty
   a_stop: assert property (p_stop) else $error("acknowledge while stopped");
   property p_align;
      MEM_REQ_O.req |-> !MEM_REQ_O.addr[0];
   endproperty
   a_align: assert property (p_align) else $error("odd word address");
   property p_timeout;
      timeout |=> (state_reg == S_IDLE) && (bitcnt_reg == 5'h00);
   endproperty
   a_timeout: assert property (p_timeout) else $error("stale transfer kept");
   property p_ack_gap;
      (state_reg == S_ACK_WAIT && state_next == S_ACK_LOW) |-> cnt_reg >= ACK_START_TICK;
   endproperty
   a_ack_gap: assert property (p_ack_gap) else $error("acknowledge too early");
   property p_ack_len;
      (state_reg == S_ACK_HI) |=> (!DEBUG_LINE_OE_N_O && DEBUG_LINE_O && (low_run_reg == ACK_LOW_TICKS))
         ##1 DEBUG_LINE_OE_N_O;
   endproperty
   a_ack_len: assert property (p_ack_len) else $error("acknowledge pulse shape wrong");
   property p_nop;
      (op_done && DBG_ACTIVE_O && !known_op && !DBG_ENTER_I)
         |=> (state_reg == S_IDLE) && (CPU_REGS_O == $past(CPU_REGS_O)) && !RESUME_O;
   endproperty
   a_nop: assert property (p_nop) else $error("unknown opcode had an effect");

endmodule
`default_nettype wire

// [verilog/dsce_pkg.sv]
// constants and carrier types for the debug serial command engine
// assumes one system clock that also serves as target and bus clock
package dsce_pkg;

   // command opcodes
   localparam logic [7:0] OP_READ_NEXT = 8'h62;
   localparam logic [7:0] OP_FETCH_PROGRAM_COUNTER = 8'h63;
   localparam logic [7:0] OP_READ_D = 8'h64;
   localparam logic [7:0] OP_READ_X = 8'h65;
   localparam logic [7:0] OP_READ_Y = 8'h66;
   localparam logic [7:0] OP_FETCH_STACK_POINTER = 8'h67;
   localparam logic [7:0] OP_WRITE_NEXT = 8'h42;
   localparam logic [7:0] OP_LOAD_PROGRAM_COUNTER = 8'h43;
   localparam logic [7:0] OP_WRITE_D = 8'h44;
   localparam logic [7:0] OP_WRITE_X = 8'h45;
   localparam logic [7:0] OP_WRITE_Y = 8'h46;
   localparam logic [7:0] OP_LOAD_STACK_POINTER = 8'h47;
   localparam logic [7:0] OP_GO = 8'h08;
   localparam logic [7:0] OP_GO_UNTIL = 8'h0c;
   localparam logic [7:0] OP_SINGLE_STEP = 8'h10;
   localparam logic [7:0] OP_LEGACY_TAG_RESUME = 8'h18;

   // frame shape
   localparam logic [4:0] OP_LAST_BIT = 5'h07;
   localparam logic [4:0] WORD_LAST_BIT = 5'h0f;

   // serial timing, in target clocks
   localparam logic [9:0] BIT_TICKS = 10'h010;
   localparam logic [9:0] SAMPLE_TICK = 10'h00a;
   localparam logic [9:0] TX0_SPEEDUP_TICK = 10'h00d;
   localparam logic [9:0] TX1_SPEEDUP_TICK = 10'h007;
   localparam logic [9:0] TIMEOUT_TICKS = 10'h200;
   localparam logic [4:0] ACK_LOW_TICKS = 5'h10;
   localparam logic [9:0] ACK_GAP_TICKS = 10'h020;
   localparam logic [9:0] ACK_START_TICK = BIT_TICKS + ACK_GAP_TICKS;

   // debug window, 0x3_ff00..0x3_ffff; registers in its first 12 bytes
   localparam logic [17:0] DBG_WIN_BASE = 18'h3ff00;
   localparam logic [7:0] DBG_WIN_PAGE = DBG_WIN_BASE[15:8];
   localparam int DBG_WIN_WORDS = 128;
   localparam logic [6:0] DBG_REG_WORDS = 7'h06;

   // reset values
   localparam logic ACTIVE_RST = 1'b0;
   localparam logic [15:0] REG_RST = 16'h0000;

   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] d;
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] sp;
   } dsce_regs_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dsce_mem_req_t;

endpackage

// [verilog/dsce_dbg_mem.sv]
// word store behind the debug window, read data registered
// assumes the caller blocks writes to read-only entries
`timescale 1ns/1ps
`default_nettype none
module dsce_dbg_mem #(
   parameter int AW = 7,
   parameter int DW = 16
) (
   input wire logic CLK_SYS_I,
   input wire logic we_i,
   input wire logic re_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] wdata_i,
   output logic [DW-1:0] rdata_o
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge CLK_SYS_I) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   // no reset on the read port: contents carry no reset either
   always_ff @(posedge CLK_SYS_I) begin
      if (re_i) begin
         rdata_o <= mem[addr_i];
      end
   end

endmodule
`default_nettype wire

// [tb/dsce_host_model.sv]
// host pod model: makes the falls on the debug line, sends and fetches bits
// assumes the bench resolves the line with a pull-up from all drivers
`timescale 1ns/1ps
`default_nettype none
module dsce_host_model (
   input wire logic clk_i,
   input wire logic line_i,
   output logic drive_low_o,
   output logic word_valid_o,
   output logic [15:0] word_o
);
   initial begin
      drive_low_o = 1'b0;
      word_valid_o = 1'b0;
      word_o = 16'h0000;
   end
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk_i);
         #5;
      end
   endtask
   // high is pulled, never driven: no clash with device speedups
   task automatic send(input logic [15:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         drive_low_o = 1'b1;
         idle(v[i] ? 4 : 13);
         drive_low_o = 1'b0;
         idle(v[i] ? 14 : 5);
      end
   endtask
   task automatic recv();
      for (int i = 15; i >= 0; i--) begin
         drive_low_o = 1'b1;
         idle(2);
         drive_low_o = 1'b0;
         idle(8);
         word_o[i] = line_i;
         idle(8);
      end
      word_valid_o = 1'b1;
      idle(1);
      word_valid_o = 1'b0;
   endtask
   // len is the low pulse length, 0 when none came within limit
   task automatic wait_ack(input int limit, output int len);
      int n;
      n = 0;
      len = 0;
      while (line_i && n < limit) begin
         idle(1);
         n++;
      end
      while (!line_i && len < 64) begin
         idle(1);
         len++;
      end
      idle(4);
   endtask
endmodule
`default_nettype wire

// [tb/dsce_engine_test.sv]
// self-checking bench for the debug serial command engine
// assumes the host model makes all falls and the line has a pull-up
`timescale 1ns/1ps
`default_nettype none
module dsce_engine_test;
   import dsce_pkg::*;
   logic CLK_SYS_I, RST_N_I, DBG_ENTER_I, ACK_EN_I, SYS_STOP_I, MEM_DONE_I;
   logic [15:0] MEM_RDATA_I;
   dsce_regs_t CPU_REGS_I;
   logic DEBUG_LINE_O, DEBUG_LINE_OE_N_O, DBG_ACTIVE_O, DEBUG_WINDOW_O, RESUME_O, STEP_O;
   dsce_regs_t CPU_REGS_O;
   dsce_mem_req_t MEM_REQ_O;
   logic host_low, rx_valid, mem_we;
   logic [15:0] rx_word, seen, mem_addr, mem_wdata, mem_rdata;
   logic [15:0] model[5];
   logic [15:0] notes[$];
   logic [31:0] seed = 32'he19a38df;
   logic [31:0] r32;
   logic [95:0] r96;
   logic [7:0] ops[4] = '{OP_GO, OP_LEGACY_TAG_RESUME, OP_GO_UNTIL, OP_SINGLE_STEP};
   int fails = 0;
   int checks = 0;
   wire logic line;
   assign line = !host_low && (DEBUG_LINE_OE_N_O || DEBUG_LINE_O);
   always #25 CLK_SYS_I = ~CLK_SYS_I;
   dsce_engine dut (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .DEBUG_LINE_I(line),
      .DBG_ENTER_I(DBG_ENTER_I), .ACK_EN_I(ACK_EN_I), .SYS_STOP_I(SYS_STOP_I),
      .CPU_REGS_I(CPU_REGS_I), .MEM_DONE_I(MEM_DONE_I), .MEM_RDATA_I(MEM_RDATA_I),
      .DEBUG_LINE_O(DEBUG_LINE_O), .DEBUG_LINE_OE_N_O(DEBUG_LINE_OE_N_O),
      .DBG_ACTIVE_O(DBG_ACTIVE_O), .DEBUG_WINDOW_O(DEBUG_WINDOW_O), .RESUME_O(RESUME_O),
      .STEP_O(STEP_O), .CPU_REGS_O(CPU_REGS_O), .MEM_REQ_O(MEM_REQ_O));
   dsce_host_model host (.clk_i(CLK_SYS_I), .line_i(line), .drive_low_o(host_low),
      .word_valid_o(rx_valid), .word_o(rx_word));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic enter();
      r96 = {rnd(), rnd(), rnd()};
      CPU_REGS_I = r96[79:0];
      {model[0], model[1], model[2], model[3], model[4]} = r96[79:0];
      DBG_ENTER_I = 1'b1;
      host.idle(1);
      DBG_ENTER_I = 1'b0;
      host.idle(1);
   endtask
   task automatic settle(input int gap);
      int len;
      if (ACK_EN_I) begin
         host.wait_ack(600, len);
         check(len[15:0], 16'h0010, "ack length");
      end else begin
         host.idle(gap);
      end
   endtask
   task automatic no_ack(input int limit);
      int len;
      host.wait_ack(limit, len);
      check(len[15:0], 16'h0000, "unexpected ack");
   endtask
   task automatic rd(input logic [7:0] op, input logic [15:0] exp);
      notes.push_back(exp);
      host.send({8'h00, op}, 8);
      settle(48);
      host.recv();
   endtask
   task automatic wr(input logic [7:0] op, input logic [15:0] val);
      host.send({8'h00, op}, 8);
      host.send(val, 16);
      settle(36);
   endtask
   // oldest note against each result word or run-control pulse
   always @(posedge CLK_SYS_I) begin
      if (rx_valid === 1'b1 || RESUME_O === 1'b1 || STEP_O === 1'b1) begin
         seen = rx_valid ? rx_word : {14'h0000, STEP_O, RESUME_O};
         check(seen, notes.size() > 0 ? notes.pop_front() : 16'hxxxx, "result");
      end
   end
   // user memory with a random answer delay
   initial forever begin
      host.idle(1);
      if (MEM_REQ_O.req === 1'b1) begin
         check(MEM_REQ_O.addr, mem_addr, "memory address");
         check({15'h0000, MEM_REQ_O.we}, {15'h0000, mem_we}, "memory direction");
         if (mem_we) check(MEM_REQ_O.wdata, mem_wdata, "memory data");
         host.idle(rnd() % 4);
         MEM_DONE_I = 1'b1;
         MEM_RDATA_I = mem_rdata;
         host.idle(1);
         MEM_DONE_I = 1'b0;
      end
   end
   initial begin
      host.idle(60000);
      fails++;
      give_verdict();
   end
   initial begin
      {CLK_SYS_I, RST_N_I, DBG_ENTER_I, ACK_EN_I, SYS_STOP_I, MEM_DONE_I} = 6'h00;
      MEM_RDATA_I = 16'h0000;
      CPU_REGS_I = '0;
      host.idle(12);
      RST_N_I = 1'b1;
      ACK_EN_I = 1'b1;
      host.send({8'h00, OP_FETCH_PROGRAM_COUNTER}, 8);
      no_ack(200);
      enter();
      check({14'h0000, DBG_ACTIVE_O, DEBUG_WINDOW_O}, 16'h0003, "debug mode");
      ACK_EN_I = 1'b0;
      for (int i = 0; i < 5; i++) rd(OP_FETCH_PROGRAM_COUNTER + i[7:0], model[i]);
      ACK_EN_I = 1'b1;
      for (int i = 0; i < 5; i++) begin
         r32 = rnd();
         model[i] = r32[15:0];
         wr(OP_LOAD_PROGRAM_COUNTER + i[7:0], model[i]);
         check(CPU_REGS_O[79 - 16 * i -: 16], model[i], "register load");
      end
      for (int i = 0; i < 5; i++) rd(OP_FETCH_PROGRAM_COUNTER + i[7:0], model[i]);
      // odd index outside the window: lsb dropped at the port
      wr(OP_WRITE_X, 16'h1001);
      {mem_addr, mem_we, r32} = {16'h1002, 1'b1, rnd()};
      mem_wdata = r32[15:0];
      wr(OP_WRITE_NEXT, mem_wdata);
      {mem_addr, mem_we, r32} = {16'h1004, 1'b0, rnd()};
      mem_rdata = r32[15:0];
      rd(OP_READ_NEXT, mem_rdata);
      rd(OP_READ_X, 16'h1005);
      // window word 0 must never reach user memory
      mem_addr = 16'hffff;
      wr(OP_WRITE_X, 16'hfefe);
      r32 = rnd();
      wr(OP_WRITE_NEXT, r32[15:0]);
      wr(OP_WRITE_X, 16'hfefe);
      rd(OP_READ_NEXT, r32[15:0]);
      host.send(16'h0055, 8);
      no_ack(200);
      check(CPU_REGS_O.x, 16'hff00, "unknown opcode");
      host.send(16'h0005, 3);
      host.idle(600);
      rd(OP_READ_X, 16'hff00);
      foreach (ops[k]) begin
         enter();
         notes.push_back(ops[k] == OP_SINGLE_STEP ? 16'h0002 : 16'h0001);
         host.send({8'h00, ops[k]}, 8);
         if (ops[k] == OP_GO || ops[k] == OP_LEGACY_TAG_RESUME) begin
            settle(76);
            check({15'h0000, DBG_ACTIVE_O}, 16'h0000, "left debug mode");
         end else begin
            no_ack(100);
            enter();
            settle(76);
         end
         host.idle(76);
      end
      enter();
      notes.push_back(16'h0001);
      host.send({8'h00, OP_GO_UNTIL}, 8);
      host.idle(4);
      SYS_STOP_I = 1'b1;
      host.idle(4);
      SYS_STOP_I = 1'b0;
      enter();
      no_ack(200);
      check(16'(notes.size()), 16'h0000, "missing results");
      give_verdict();
   end
endmodule
`default_nettype wire
